// *** common/brs_pkg.sv ***
package brs_pkg;

  // ----------------------------------------------------------------
  // Boot addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] BRS_RESET_VECTOR = 32'hA000_0000;  // First fetch address
  localparam logic [31:0] BRS_SEG_BASE = 32'hA000_0000;      // Direct segment virtual base
  localparam logic [31:0] BRS_PHYS_LOW = 32'h0000_0000;      // Physical window start
  localparam logic [31:0] BRS_PHYS_HIGH = 32'h2000_0000;     // Physical window upper bound
  localparam logic [2:0] BRS_SEG_TOP_BITS = 3'h5;            // Top three bits of the segment
  localparam logic [31:0] BRS_OFFSET_MASK = 32'h1FFF_FFFF;   // Offset inside a segment
  localparam logic [31:0] BRS_CS_SPAN_MASK = 32'hFC00_0000;  // 64 Mbyte chip select windows

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BRS_CLK_HZ = 20_000_000;                    // System clock rate
  localparam int BRS_OSC_SETTLE_US = 1000;                   // Crystal settling time, least
  localparam int BRS_OSC_SETTLE_CYC = (BRS_OSC_SETTLE_US * (BRS_CLK_HZ / 1_000_000));
  localparam int BRS_CNT_W = 16;                             // Settle counter width
  localparam logic [7:0] BRS_DIV_RESET = 8'h00;              // Divider after reset: undivided
  localparam int BRS_NUM_CLK = 8;                            // Module clock branches

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BRS_SEL_BOOT, BRS_SEL_OTHER_CS, BRS_SEL_NONE} brs_sel_e;

  // Software clock setup carried as one bundle
  typedef struct packed {
    logic pll_enable;
    logic [7:0] periph_div;
    logic [BRS_NUM_CLK-1:0] clk_gate_off;
  } brs_clkcfg_s;

  // Fetch request from the processor
  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
  } brs_fetch_s;

endpackage

// *** rtl/brs_sync.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Two stage synchroniser for pins from outside the clock domain
// ------------------------------------------------------------------
module brs_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Async level in, synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_r;  // First stage, read only by the second
  logic q_r;     // Second stage

  // Both stages reset to zero so a low pin reads as inactive
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// *** rtl/brs_sequencer.sv ***
`timescale 1ns/100ps
module brs_sequencer
  import brs_pkg::*;
#(
  parameter int SETTLE_CYC = BRS_OSC_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Supply and strap
  input wire logic por_ok,
  input wire logic oscillator_strap_pin,
  // Software clock setup after boot
  input wire brs_pkg::brs_clkcfg_s clkcfg,
  input wire logic clkcfg_we,
  // Processor fetch
  input wire brs_pkg::brs_fetch_s fetch,
  // Reset and clock state
  output logic sys_resetn,
  output logic clk_src_primary,
  output logic crystal_mode,
  output logic pll_enable,
  output logic [7:0] periph_div,
  output logic [BRS_NUM_CLK-1:0] clk_run,
  // Boot vector and decode
  output logic [31:0] boot_pc,
  output logic [31:0] phys_addr,
  output logic uncached,
  output logic boot_chip_select,
  output logic decode_valid
);
  import brs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic por_s;    // Supply good, synchronised
  logic strap_s;  // Strap level, synchronised; low means crystal

  brs_sync u_por (.clk(clk), .resetn(resetn), .d(por_ok), .q(por_s));
  brs_sync u_strap (.clk(clk), .resetn(resetn), .d(oscillator_strap_pin), .q(strap_s));

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_POR, ST_STRAP, ST_SETTLE, ST_RUN} brs_state_e;

  brs_state_e state_r, state_nxt;
  logic [BRS_CNT_W-1:0] cnt_r, cnt_nxt;   // Settle counter
  logic xtal_r, xtal_nxt;                 // Captured strap
  logic rel_r, rel_nxt;                   // Internal reset released
  logic src_r, src_nxt;                   // Primary input selected
  localparam logic [BRS_CNT_W-1:0] SETTLE_LAST = BRS_CNT_W'(SETTLE_CYC - 1);

  // Next state: wait for supply, sample strap, settle if crystal, run
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    xtal_nxt = xtal_r;
    rel_nxt = rel_r;
    src_nxt = src_r;
    unique case (state_r)
      ST_POR: begin
        // Everything stays in reset while supply is low
        if (por_s) begin
          state_nxt = ST_STRAP;
          src_nxt = 1'b1;
        end
      end
      ST_STRAP: begin
        // Strap is caught after supply is good, while internal reset is still held
        xtal_nxt = ~strap_s;
        cnt_nxt = '0;
        state_nxt = strap_s ? ST_RUN : ST_SETTLE;
      end
      ST_SETTLE: begin
        // Crystal: count settle cycles before release
        if (cnt_r == SETTLE_LAST) begin
          state_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_RUN: begin
        rel_nxt = 1'b1;
      end
    endcase
    // A supply dip drops straight back into reset
    if (!por_s) begin
      state_nxt = ST_POR;
      rel_nxt = 1'b0;
    end
  end

  // Register sequencer state; release is one flop so all leave together
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_POR;
      cnt_r <= '0;
      xtal_r <= 1'b0;
      rel_r <= 1'b0;
      src_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      xtal_r <= xtal_nxt;
      rel_r <= rel_nxt;
      src_r <= src_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Clock configuration
  // ----------------------------------------------------------------
  logic pll_r, pll_nxt;
  logic [7:0] div_r, div_nxt;
  logic [BRS_NUM_CLK-1:0] run_r, run_nxt;

  // Defaults hold while in reset; writes only count once running
  always_comb begin
    pll_nxt = pll_r;
    div_nxt = div_r;
    run_nxt = run_r;
    if (!rel_r) begin
      pll_nxt = 1'b0;
      div_nxt = BRS_DIV_RESET;
      run_nxt = '1;
    end else if (clkcfg_we) begin
      pll_nxt = clkcfg.pll_enable;
      div_nxt = clkcfg.periph_div;
      run_nxt = ~clkcfg.clk_gate_off;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pll_r <= 1'b0;
      div_r <= BRS_DIV_RESET;
      run_r <= '1;
    end else begin
      pll_r <= pll_nxt;
      div_r <= div_nxt;
      run_r <= run_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fetch address decode
  // ----------------------------------------------------------------
  // Direct segment: strip the top bits, no translation or cache
  function automatic logic [31:0] seg_to_phys(input logic [31:0] va);
    seg_to_phys = va & BRS_OFFSET_MASK;
  endfunction

  logic [31:0] pa_r, pa_nxt;
  logic unc_r, unc_nxt;
  logic cs_r, cs_nxt;
  logic dv_r, dv_nxt;
  brs_sel_e sel;  // Target of the current fetch

  // Only the direct segment is decoded here; others go elsewhere
  always_comb begin
    pa_nxt = pa_r;
    unc_nxt = unc_r;
    cs_nxt = 1'b0;
    dv_nxt = 1'b0;
    sel = BRS_SEL_NONE;
    if (rel_r && fetch.valid && fetch.vaddr[31:29] == BRS_SEG_TOP_BITS) begin
      pa_nxt = seg_to_phys(fetch.vaddr);
      unc_nxt = 1'b1;
      dv_nxt = 1'b1;
      sel = ((pa_nxt & BRS_CS_SPAN_MASK) == BRS_PHYS_LOW) ? BRS_SEL_BOOT : BRS_SEL_OTHER_CS;
      cs_nxt = (sel == BRS_SEL_BOOT);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pa_r <= BRS_PHYS_LOW;
      unc_r <= 1'b0;
      cs_r <= 1'b0;
      dv_r <= 1'b0;
    end else begin
      pa_r <= pa_nxt;
      unc_r <= unc_nxt;
      cs_r <= cs_nxt;
      dv_r <= dv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  logic [31:0] pc_r;
  always_ff @(posedge clk) begin
    pc_r <= BRS_RESET_VECTOR;
  end

  assign sys_resetn = rel_r;
  assign clk_src_primary = src_r;
  assign crystal_mode = xtal_r;
  assign pll_enable = pll_r;
  assign periph_div = div_r;
  assign clk_run = run_r;
  assign boot_pc = pc_r;
  assign phys_addr = pa_r;
  assign uncached = unc_r;
  assign boot_chip_select = cs_r;
  assign decode_valid = dv_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  no_rel_por_a: assert property (@(posedge clk) disable iff (!resetn)
    !por_s |=> !sys_resetn) else $error("reset released without supply");
  ext_fast_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == ST_STRAP && strap_s && por_s) ##1 por_s [*1] |=> sys_resetn)
    else $error("external clock release late");
  xtal_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == ST_SETTLE && cnt_r < SETTLE_LAST) |=> !sys_resetn)
    else $error("crystal released before settle");
  pll_off_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(sys_resetn) |-> !pll_enable && clk_run == '1 && periph_div == BRS_DIV_RESET)
    else $error("clocks not at default on release");
  src_sel_a: assert property (@(posedge clk) disable iff (!resetn)
    sys_resetn |-> clk_src_primary) else $error("primary clock not selected");
  strap_cap_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == ST_STRAP |=> crystal_mode == !$past(strap_s)) else $error("strap not captured");
  boot_cs_a: assert property (@(posedge clk) disable iff (!resetn)
    (rel_r && fetch.valid && fetch.vaddr == BRS_RESET_VECTOR)
    |=> boot_chip_select && phys_addr == BRS_PHYS_LOW && uncached)
    else $error("reset vector not on boot chip select");
  // Ties each decode to the fetch one cycle earlier, not only to the window
  seg_map_a: assert property (@(posedge clk) disable iff (!resetn)
    decode_valid |-> uncached && phys_addr < BRS_PHYS_HIGH
    && phys_addr == ($past(fetch.vaddr) & BRS_OFFSET_MASK)) else $error("segment outside window");
  cfg_wr_a: assert property (@(posedge clk) disable iff (!resetn)
    (rel_r && clkcfg_we) |=> pll_enable == $past(clkcfg.pll_enable)) else $error("pll write lost");
  vec_a: assert property (@(posedge clk) disable iff (!resetn)
    sys_resetn |-> boot_pc == BRS_RESET_VECTOR) else $error("wrong reset vector");
  rel_once_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(sys_resetn) |-> $past(state_r) == ST_RUN) else $error("release not from run state");

endmodule

// *** verif/brs_board_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Board model: supply monitor and oscillator strap
// ------------------------------------------------------------------
module brs_board_model #(
  parameter int RAMP_CYC = 5  // Supply ramp length in clocks
) (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic power_on,
  input wire logic use_crystal,
  // Pins toward the device
  output logic por_ok,
  output logic oscillator_strap_pin
);
  int ramp_cnt = 0;  // Clocks since power was applied

  // Both pins are defined from time zero so the synchronisers never see X
  initial begin
    por_ok = 1'b0;
    oscillator_strap_pin = 1'b1;
  end

  // Supply is good only after a full ramp; it drops at once on power loss
  always @(posedge clk) begin
    ramp_cnt <= power_on ? ramp_cnt + 1 : 0;
    por_ok <= power_on && (ramp_cnt >= RAMP_CYC);
  end

  // Strap is a fixed tie, low selects a crystal; bench changes it only unpowered
  always @(posedge clk) oscillator_strap_pin <= !use_crystal;
endmodule

// *** verif/brs_sequencer_bench.sv ***
`timescale 1ns/100ps
module brs_sequencer_bench;
  import brs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int SETTLE = 8;  // Short crystal settle for simulation
  localparam int RAMP = 5;  // Supply ramp of the board model
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic power_on = 1'b0;
  logic use_crystal = 1'b0;
  logic por_ok, oscillator_strap_pin;
  brs_clkcfg_s clkcfg = '0;
  logic clkcfg_we = 1'b0;
  brs_fetch_s fetch = '0;
  logic sys_resetn, clk_src_primary, crystal_mode, pll_enable, uncached, boot_chip_select, decode_valid;
  logic [7:0] periph_div, clk_run;
  logic [31:0] boot_pc, phys_addr;
  logic [32:0] exp_q[$];  // Pending decodes: chip select hit and physical address
  logic [32:0] e;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'hCF49;

  always #25 clk = ~clk;

  brs_board_model #(.RAMP_CYC(RAMP)) u_board (.clk(clk), .power_on(power_on), .use_crystal(use_crystal),
    .por_ok(por_ok), .oscillator_strap_pin(oscillator_strap_pin));

  brs_sequencer #(.SETTLE_CYC(SETTLE)) u_dut (.clk(clk), .resetn(resetn), .por_ok(por_ok),
    .oscillator_strap_pin(oscillator_strap_pin), .clkcfg(clkcfg), .clkcfg_we(clkcfg_we), .fetch(fetch),
    .sys_resetn(sys_resetn), .clk_src_primary(clk_src_primary), .crystal_mode(crystal_mode),
    .pll_enable(pll_enable), .periph_div(periph_div), .clk_run(clk_run), .boot_pc(boot_pc),
    .phys_addr(phys_addr), .uncached(uncached), .boot_chip_select(boot_chip_select),
    .decode_valid(decode_valid));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Counts clocks until internal reset reaches a level; sampled mid-cycle
  task automatic wait_reset(input logic lvl, output int n);
    n = 0;
    while (sys_resetn !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        check("sys_resetn wait", 32'(sys_resetn), 32'(lvl));
        complete_run();
      end
    end
  endtask

  // Power loss, strap change while unpowered, then power up again
  task automatic power_cycle(input logic xtal, output int n);
    int d;
    @(posedge clk) power_on <= 1'b0;
    wait_reset(1'b0, d);
    repeat (4) @(posedge clk);
    use_crystal <= xtal;
    repeat (4) @(posedge clk);
    power_on <= 1'b1;
    wait_reset(1'b1, n);
  endtask

  // ----------------------------------------------------------------
  // Decode monitor: each decode pulse consumes the oldest expectation
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (decode_valid === 1'b1) begin
      if (exp_q.size() == 0) check("stray decode", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check("phys_addr", phys_addr, e[31:0]);
        check("uncached", 32'(uncached), 32'h1);
        check("boot_chip_select", 32'(boot_chip_select), 32'(e[32]));
      end
    end
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    check("run length", 32'h1, 32'h0);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n_ext, n_xtal, i;
    logic [31:0] r, va, pa;
    brs_clkcfg_s cfg, prev;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check("pll_enable", 32'(pll_enable), 32'h0);
    check("periph_div", 32'(periph_div), 32'(BRS_DIV_RESET));
    check("clk_run", 32'(clk_run), 32'hFF);
    check("boot_pc", boot_pc, BRS_RESET_VECTOR);
    check("clk_src_primary", 32'(clk_src_primary), 32'h0);
    // A setup write while still held in reset must be dropped
    @(posedge clk);
    clkcfg <= '{1'b1, 8'h05, 8'hFF};
    clkcfg_we <= 1'b1;
    @(posedge clk) clkcfg_we <= 1'b0;
    repeat (2) @(negedge clk);
    check("pll_enable", 32'(pll_enable), 32'h0);
    check("sys_resetn", 32'(sys_resetn), 32'h0);
    $display("test reset state done");
    power_cycle(1'b0, n_ext);
    check("clk_src_primary", 32'(clk_src_primary), 32'h1);
    check("crystal_mode", 32'(crystal_mode), 32'h0);
    check("released after supply", 32'(n_ext > RAMP), 32'h1);
    $display("test external clock done");
    // Back-to-back fetches: vector first, then random offsets, then two foreign segments
    for (i = 0; i < 11; i++) begin
      r = $random(seed);
      va = {BRS_SEG_TOP_BITS, r[28:0]};
      if (i[0] == 1'b0) va[28:26] = 3'h0;
      if (i == 0) va = BRS_RESET_VECTOR;
      if (i >= 9) va = {i[0] ? 3'h4 : 3'h6, r[28:0]};
      pa = va & BRS_OFFSET_MASK;
      if (va[31:29] == BRS_SEG_TOP_BITS) exp_q.push_back({(pa & BRS_CS_SPAN_MASK) == 32'h0, pa});
      @(posedge clk) fetch <= '{1'b1, va};
    end
    @(posedge clk) fetch <= '0;
    repeat (4) @(negedge clk);
    check("missing decodes", 32'(exp_q.size()), 32'h0);
    $display("test fetch decode done");
    // Back-to-back clock setup writes after boot
    r = $random(seed);
    cfg = r[16:0];
    @(posedge clk);
    clkcfg <= cfg;
    clkcfg_we <= 1'b1;
    for (i = 0; i < 3; i++) begin
      prev = cfg;
      r = $random(seed);
      cfg = r[16:0];
      @(posedge clk);
      clkcfg <= cfg;
      if (i == 2) clkcfg_we <= 1'b0;
      @(negedge clk);
      check("pll_enable", 32'(pll_enable), 32'(prev.pll_enable));
      check("periph_div", 32'(periph_div), 32'(prev.periph_div));
      check("clk_run", 32'(clk_run), {24'h0, ~prev.clk_gate_off});
    end
    $display("test clock setup done");
    power_cycle(1'b1, n_xtal);
    check("crystal_mode", 32'(crystal_mode), 32'h1);
    // Setup written before the power loss must not survive the new start-up
    check("pll_enable", 32'(pll_enable), 32'h0);
    check("periph_div", 32'(periph_div), 32'(BRS_DIV_RESET));
    check("clk_run", 32'(clk_run), 32'hFF);
    check("settle delay", 32'(n_xtal >= n_ext + SETTLE && n_xtal <= n_ext + SETTLE + 2), 32'h1);
    $display("test crystal start done");
    complete_run();
  end
endmodule
